// *** rtl/mftwd_params.svh ***
// constants of the timer and watchdog unit
`ifndef MFTWD_PARAMS_SVH
`define MFTWD_PARAMS_SVH
`define MFTWD_CTRL_ADDR 16'h001c
`define MFTWD_SVC_ADDR 16'hfff0
`define MFTWD_CTRL_RESET 8'h03
`define MFTWD_BIT_TOF 7
`define MFTWD_BIT_PERIODIC_IRQ_FLAG 6
`define MFTWD_BIT_RIPPLE_OVERFLOW_IRQ_ENABLE 5
`define MFTWD_BIT_PERIODIC_IRQ_ENABLE 4
`define MFTWD_BIT_EDGE 3
`define MFTWD_BIT_WDEN 2
`define MFTWD_BIT_RSH 1
`define MFTWD_BIT_RSL 0
`define MFTWD_PRESCALE 4
`define MFTWD_RIPPLE_W 8
`define MFTWD_PER_W 4
`define MFTWD_WD_DIV 8
`define MFTWD_STOP_WAKE_CYC 4064
`define MFTWD_BUS_MHZ_X10 42
`define MFTWD_PER_BASE_DIV 16384
`define MFTWD_RST_VEC_HI 16'hfffe
`define MFTWD_RST_VEC_LO 16'hffff
`endif

// *** rtl/mftwd_pkg.sv ***
// types of the timer and watchdog unit
package mftwd_pkg;
  typedef enum logic [1:0] {
    MFTWD_RUN,
    MFTWD_HALT,
    MFTWD_WAKE_DELAY
  } mftwd_wd_state_t;
  typedef logic [1:0] mftwd_rate_t;
endpackage

// *** rtl/mftwd_tick_if.sv ***
// tick and control bundle between the timer core parts
interface mftwd_tick_if;
  logic ripple_tick;
  logic periodic_tick;
  logic [1:0] rate_sel;
  modport source (output ripple_tick, output periodic_tick, input rate_sel);
  modport sink (input ripple_tick, input periodic_tick, output rate_sel);
endinterface

// *** rtl/mftwd_divider.sv ***
// prescaler, ripple counter and periodic divider
`include "mftwd_params.svh"
module mftwd_divider
  import mftwd_pkg::*;
#(
  parameter int RIPPLE_W = `MFTWD_RIPPLE_W,
  parameter int PER_W = `MFTWD_PER_W
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  mftwd_tick_if.source tk
);
  logic [1:0] pre_ff;
  logic [RIPPLE_W-1:0] ripple_ff;
  // three stages past the base divider cover the slowest rate, eight base periods
  localparam int PER_TOP = PER_W + 3;
  localparam logic [PER_TOP-1:0] PER_ONES = '1;
  logic [PER_TOP-1:0] per_ff;
  logic pre_tick;
  logic ripple_wrap;
  logic [PER_TOP-1:0] per_mask;
  assign pre_tick = (pre_ff == 2'h3);
  assign ripple_wrap = pre_tick && (ripple_ff == {RIPPLE_W{1'b1}});
  assign per_mask = ~(PER_ONES << (PER_W + int'(tk.rate_sel)));
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pre_ff <= 2'h0;
      ripple_ff <= '0;
      per_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 2'h1;
      if (pre_tick)
        ripple_ff <= ripple_ff + 1'b1;
      if (ripple_wrap)
        per_ff <= per_ff + 1'b1;
    end
  end
  assign tk.ripple_tick = ripple_wrap;
  // base period is 16 wraps; each rate step doubles the wraps needed before a tick
  assign tk.periodic_tick = ripple_wrap && ((per_ff & per_mask) == per_mask);
endmodule

// *** rtl/mftwd_watchdog.sv ***
// watchdog counter with low power halt and stop wake delay
`include "mftwd_params.svh"
module mftwd_watchdog
  import mftwd_pkg::*;
#(
  parameter int WAKE_CYC = `MFTWD_STOP_WAKE_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic service,
  input wire logic wait_mode,
  input wire logic stop_mode,
  mftwd_tick_if.sink tk,
  input wire logic [1:0] rate,
  output logic timeout
);
  mftwd_wd_state_t state_ff, nxt_state;
  logic [2:0] cnt_ff;
  logic [12:0] wake_ff;
  logic was_stop_ff;
  logic counting;
  assign tk.rate_sel = rate;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      MFTWD_RUN: if (wait_mode || stop_mode) nxt_state = MFTWD_HALT;
      MFTWD_HALT: if (!wait_mode && !stop_mode) nxt_state = was_stop_ff ? MFTWD_WAKE_DELAY : MFTWD_RUN;
      MFTWD_WAKE_DELAY: if (wake_ff == 13'(WAKE_CYC - 1)) nxt_state = MFTWD_RUN;
      default: nxt_state = MFTWD_RUN;
    endcase
  end
  assign counting = enable && (state_ff == MFTWD_RUN) && !wait_mode && !stop_mode;
  assign timeout = counting && tk.periodic_tick && (cnt_ff == 3'h7) && !service;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_ff <= MFTWD_RUN;
      cnt_ff <= 3'h0;
      wake_ff <= 13'h0;
      was_stop_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (stop_mode)
        was_stop_ff <= 1'b1;
      else if (state_ff == MFTWD_RUN)
        was_stop_ff <= 1'b0;
      wake_ff <= (state_ff == MFTWD_WAKE_DELAY) ? wake_ff + 13'h1 : 13'h0;
      if (service || !enable)
        cnt_ff <= 3'h0;
      else if (counting && tk.periodic_tick)
        cnt_ff <= cnt_ff + 3'h1;
    end
  end
  timeout_bound_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    timeout |-> enable && !service) else $error("timeout while disabled or serviced");
  halt_stops_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (wait_mode || stop_mode) |-> !timeout) else $error("timeout in low power");
  wake_delay_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_ff == MFTWD_HALT && was_stop_ff && !wait_mode && !stop_mode) |=> state_ff == MFTWD_WAKE_DELAY)
    else $error("stop wake skipped delay");
  wait_wake_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (state_ff == MFTWD_HALT && !was_stop_ff && !wait_mode && !stop_mode) |=> state_ff == MFTWD_RUN)
    else $error("wait wake delayed");
endmodule

// *** rtl/mftwd_top.sv ***
// timer, periodic interrupt and watchdog unit with APB slave
//
// Added by the designer: register access over APB.
`include "mftwd_params.svh"
module mftwd_top
  import mftwd_pkg::*;
#(
  parameter int WAKE_CYC = `MFTWD_STOP_WAKE_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic ext_irq_n,
  output logic ext_irq_req,
  output logic ripple_irq,
  output logic periodic_irq,
  output logic wd_reset_req,
  output logic [15:0] reset_vector_addr
);
  mftwd_tick_if tk ();
  logic tof_ff, periodic_irq_flag_ff, ripple_overflow_irq_enable_ff, periodic_irq_enable_ff, edge_only_ff, wden_ff;
  logic [1:0] rate_ff;
  logic [31:0] prdata_ff;
  logic wd_reset_ff;
  logic ext_prev_ff, ext_pend_ff;
  logic acc, wr, rd, hit_ctrl, hit_svc, wr_ctrl, svc_wr, timeout;
  logic [7:0] ctrl_rd;

  // access completes in the first access cycle, so pready is combinational
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign hit_ctrl = (paddr == `MFTWD_CTRL_ADDR);
  assign hit_svc = (paddr == `MFTWD_SVC_ADDR);
  assign wr_ctrl = wr && hit_ctrl;
  assign svc_wr = wr && hit_svc && !pwdata[0];
  assign pready = 1'b1;
  assign pslverr = acc && !hit_ctrl && !hit_svc;
  assign ctrl_rd = {tof_ff, periodic_irq_flag_ff, ripple_overflow_irq_enable_ff, periodic_irq_enable_ff, edge_only_ff, wden_ff, rate_ff};
  assign prdata = prdata_ff;

  mftwd_divider u_div (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tk(tk)
  );

  mftwd_watchdog #(.WAKE_CYC(WAKE_CYC)) u_wd (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .enable(wden_ff),
    .service(svc_wr),
    .wait_mode(wait_mode),
    .stop_mode(stop_mode),
    .tk(tk),
    .rate(rate_ff),
    .timeout(timeout)
  );

  assign ripple_irq = tof_ff && ripple_overflow_irq_enable_ff;
  assign periodic_irq = periodic_irq_flag_ff && periodic_irq_enable_ff;
  // level plus edge, or edge only
  assign ext_irq_req = ext_pend_ff || (!edge_only_ff && !ext_irq_n);
  assign wd_reset_req = wd_reset_ff;
  assign reset_vector_addr = `MFTWD_RST_VEC_HI;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      tof_ff <= 1'b0;
      periodic_irq_flag_ff <= 1'b0;
      ripple_overflow_irq_enable_ff <= 1'b0;
      periodic_irq_enable_ff <= 1'b0;
      edge_only_ff <= 1'b0;
      wden_ff <= 1'b0;
      rate_ff <= 2'h3;
      prdata_ff <= 32'h0;
      wd_reset_ff <= 1'b0;
      ext_prev_ff <= 1'b1;
      ext_pend_ff <= 1'b0;
    end else begin
      if (tk.ripple_tick)
        tof_ff <= 1'b1;
      else if (wr_ctrl && !pwdata[`MFTWD_BIT_TOF])
        tof_ff <= 1'b0;
      if (tk.periodic_tick)
        periodic_irq_flag_ff <= 1'b1;
      else if (wr_ctrl && !pwdata[`MFTWD_BIT_PERIODIC_IRQ_FLAG])
        periodic_irq_flag_ff <= 1'b0;
      if (wr_ctrl) begin
        ripple_overflow_irq_enable_ff <= pwdata[`MFTWD_BIT_RIPPLE_OVERFLOW_IRQ_ENABLE];
        periodic_irq_enable_ff <= pwdata[`MFTWD_BIT_PERIODIC_IRQ_ENABLE];
        edge_only_ff <= pwdata[`MFTWD_BIT_EDGE];
        rate_ff <= pwdata[`MFTWD_BIT_RSH:`MFTWD_BIT_RSL];
      end
      if (wr_ctrl && pwdata[`MFTWD_BIT_WDEN])
        wden_ff <= 1'b1;
      // captured in the setup cycle so the data stands when pready is sampled
      if (psel && !penable && !pwrite)
        prdata_ff <= hit_ctrl ? {24'h0, ctrl_rd} : 32'h0;
      // the reset request holds until the chip reset comes back around
      if (timeout)
        wd_reset_ff <= 1'b1;
      ext_prev_ff <= ext_irq_n;
      if (ext_prev_ff && !ext_irq_n)
        ext_pend_ff <= 1'b1;
      else if (wr_ctrl)
        ext_pend_ff <= 1'b0;
    end
  end

  tof_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tk.ripple_tick |=> tof_ff) else $error("overflow flag not set");
  tof_clr_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (wr_ctrl && !pwdata[7] && !tk.ripple_tick) |=> !tof_ff) else $error("overflow flag not cleared");
  periodic_irq_flag_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tk.periodic_tick |=> periodic_irq_flag_ff) else $error("periodic flag not set");
  periodic_irq_flag_clr_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (wr_ctrl && !pwdata[6] && !tk.periodic_tick) |=> !periodic_irq_flag_ff) else $error("periodic flag not cleared");
  irq_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ripple_irq == (tof_ff && ripple_overflow_irq_enable_ff)) else $error("ripple request gating wrong");
  wden_sticky_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wden_ff |=> wden_ff) else $error("watchdog enable cleared");
  wd_reset_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    timeout |=> wd_reset_req) else $error("no reset after timeout");
  flag_keep_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (wr_ctrl && pwdata[7] && tof_ff) |=> tof_ff) else $error("one write changed flag");
endmodule

// *** test/tb_top.sv ***
// self-checking bench for the timer, periodic interrupt and watchdog unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] w; logic pin; logic req;} mftwd_tb_row_t;
  localparam logic [15:0] CTRL = 16'h001c;
  logic sys_clk = 1'h0;
  logic reset_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0;
  logic wait_mode = 1'h0;
  logic stop_mode = 1'h0;
  logic ext_irq_n = 1'h1;
  logic [31:0] prdata;
  logic pready, pslverr, ext_irq_req, ripple_irq, periodic_irq, wd_reset_req;
  logic [15:0] reset_vector_addr;
  logic [31:0] rd;
  logic er;
  int err_total = 0;
  int num_checks = 0;
  int c;
  // level mode follows the pin; edge mode only latches falling edges, and a ctrl write drops the latch
  mftwd_tb_row_t rows[9] = '{'{8'h00, 1'h1, 1'h0}, '{8'h01, 1'h0, 1'h1}, '{8'h02, 1'h0, 1'h1},
    '{8'h03, 1'h1, 1'h0}, '{8'h08, 1'h0, 1'h0}, '{8'h0b, 1'h1, 1'h0}, '{8'h10, 1'h1, 1'h0},
    '{8'h20, 1'h0, 1'h1}, '{8'h33, 1'h0, 1'h1}};

  mftwd_top #(.WAKE_CYC(8)) DUT (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .ext_irq_n(ext_irq_n), .ext_irq_req(ext_irq_req),
    .ripple_irq(ripple_irq), .periodic_irq(periodic_irq), .wd_reset_req(wd_reset_req),
    .reset_vector_addr(reset_vector_addr));

  initial forever #12.5 sys_clk = ~sys_clk;

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // entered right after a rising edge; read data and error are taken at the pready edge
  task xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    penable <= 1'h0;
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    while (pready !== 1'h1 && k < 50) begin
      k++;
      @(posedge sys_clk);
    end
    if (k >= 50) begin
      err_total++;
      $display("Error %0t: no pready", $time);
    end
    er = pslverr;
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask

  task wait_irq(input bit per);
    c = 0;
    while ((per ? periodic_irq : ripple_irq) !== 1'h1 && c < 40000) begin
      @(posedge sys_clk);
      c++;
    end
  endtask

  task close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (120000) @(posedge sys_clk);
    err_total++;
    $display("Error %0t: run did not finish", $time);
    close_out;
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'h1;
    @(posedge sys_clk);
    xfer(1'h0, CTRL, 8'h00);
    chk(rd[7:0], 8'h03, "ctrl reset value");
    chk(wd_reset_req, 1'h0, "no reset request");
    chk(reset_vector_addr, 16'hfffe, "vector address");
    foreach (rows[i]) begin
      ext_irq_n <= rows[i].pin;
      @(posedge sys_clk);
      xfer(1'h1, CTRL, rows[i].w);
      xfer(1'h0, CTRL, 8'h00);
      chk(rd[5:0], rows[i].w[5:0], "ctrl readback");
      chk(ext_irq_req, rows[i].req, "pin request");
    end
    xfer(1'h0, 16'h0040, 8'h00);
    chk({er, rd}, 33'h100000000, "unmapped read");
    ext_irq_n <= 1'h1;
    xfer(1'h1, CTRL, 8'h20);
    wait_irq(1'h0);
    xfer(1'h0, CTRL, 8'h00);
    chk(rd[7], 1'h1, "overflow flag set");
    xfer(1'h1, CTRL, 8'ha0);
    chk(ripple_irq, 1'h1, "flag kept by write one");
    xfer(1'h1, CTRL, 8'h80);
    chk(ripple_irq, 1'h0, "overflow request gated");
    xfer(1'h1, CTRL, 8'h20);
    chk(ripple_irq, 1'h0, "overflow flag cleared");
    wait_irq(1'h0);
    xfer(1'h1, CTRL, 8'h20);
    wait_irq(1'h0);
    chk((c + 3) inside {[1023:1025]}, 1'h1, "overflow period");
    // rate 00 keeps the periodic wait to one base period
    xfer(1'h1, CTRL, 8'h10);
    wait_irq(1'h1);
    xfer(1'h1, CTRL, 8'h10);
    wait_irq(1'h1);
    chk((c + 3) inside {[16383:16385]}, 1'h1, "periodic period");
    xfer(1'h1, 16'hfff0, 8'h00);
    xfer(1'h1, CTRL, 8'h11);
    wait_irq(1'h1);
    xfer(1'h1, CTRL, 8'h11);
    wait_irq(1'h1);
    chk((c + 3) inside {[32767:32769]}, 1'h1, "periodic period rate one");
    xfer(1'h1, CTRL, 8'h40);
    chk(periodic_irq, 1'h0, "periodic request gated");
    xfer(1'h0, CTRL, 8'h00);
    chk(rd[6], 1'h1, "periodic flag set");
    xfer(1'h1, CTRL, 8'h00);
    xfer(1'h0, CTRL, 8'h00);
    chk(rd[6], 1'h0, "periodic flag cleared");
    xfer(1'h1, CTRL, 8'h04);
    xfer(1'h0, CTRL, 8'h00);
    chk(rd[2], 1'h1, "watchdog enabled");
    xfer(1'h1, CTRL, 8'h00);
    xfer(1'h0, CTRL, 8'h00);
    chk(rd[2], 1'h1, "enable stays set");
    repeat (3) begin
      xfer(1'h1, 16'hfff0, 8'h00);
      chk(er, 1'h0, "service accepted");
    end
    wait_mode <= 1'h1;
    repeat (40) @(posedge sys_clk);
    wait_mode <= 1'h0;
    stop_mode <= 1'h1;
    repeat (40) @(posedge sys_clk);
    stop_mode <= 1'h0;
    repeat (20) @(posedge sys_clk);
    chk(wd_reset_req, 1'h0, "no timeout while serviced");
    xfer(1'h1, CTRL, 8'h08);
    ext_irq_n <= 1'h0;
    repeat (3) @(posedge sys_clk);
    chk(ext_irq_req, 1'h1, "falling edge latched");
    ext_irq_n <= 1'h1;
    repeat (3) @(posedge sys_clk);
    chk(ext_irq_req, 1'h1, "edge held after pin rises");
    close_out;
  end
endmodule
